// ### shared/jpm_consts.vh
// Constants for the CAN parameter-map port: register offsets, field
// positions, reset values, frame tags and the broadcast period.
// Assumes a 29-bit extended identifier and an 8-byte payload vector
// with payload byte 0 in bits 7:0.
`ifndef JPM_CONSTS_VH
`define JPM_CONSTS_VH

// Clock rate and broadcast period
`define JPM_CLK_KHZ 100000
`define JPM_PERIOD_MS 1000

// Register byte offsets on the bus
`define JPM_REG_CTRL 5'h00
`define JPM_REG_MINSPD 5'h04
`define JPM_REG_MAXSPD 5'h08
`define JPM_REG_STATUS 5'h0C

// Control register fields and register reset values
`define JPM_CTRL_EN 0
`define JPM_CTRL_SA_LO 8
`define JPM_CTRL_SA_HI 15
`define JPM_CTRL_RST 32'h0000_0000
`define JPM_MINSPD_RST 16'h0000
`define JPM_MAXSPD_RST 16'h0000

// Identification bytes at the head of every payload
`define JPM_TX_TAG0 8'hA3
`define JPM_TX_TAG1 8'hAD
`define JPM_RX_TAG0 8'hA5
`define JPM_RX_TAG1 8'hAD

// Identifier fields of received frames
`define JPM_PRIO 5'h18
`define JPM_HOST_SA 8'h70

// Group numbers of the map
`define JPM_PGN_SPEED 16'hFF90
`define JPM_PGN_MINSPD 16'hFF91
`define JPM_PGN_MAXSPD 16'hFF92
`define JPM_PGN_ANALOG 16'hFF93
`define JPM_PGN_HOURS 16'hFF94
`define JPM_PGN_STATE 16'hFF95
`define JPM_PGN_SAVE 16'hFFBB

// Payload field positions and frames per burst
`define JPM_SAVE_BIT 16
`define JPM_NFRAMES 3'd7
`define JPM_FILL 8'hFF

`endif

// ### hdl/jpm_tick.v
// One-pulse-per-period tick generator for the map broadcast.
// Assumes one clock; the count restarts whenever en_i is low.
`timescale 1ns/1ps
`default_nettype none

module jpm_tick #(
  parameter [31:0] CYCLES = 32'd100000000
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Control and tick
  input wire en_i,
  output reg tick_o
);

  localparam [31:0] LAST = CYCLES - 32'd1;

  reg [31:0] cnt_reg;

  // Counts whole periods while enabled, one-cycle tick at the end
  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= 32'h0000_0000;
      tick_o <= 1'b0;
    end else if (!en_i) begin
      cnt_reg <= 32'h0000_0000;
      tick_o <= 1'b0;
    end else if (cnt_reg >= LAST) begin
      cnt_reg <= 32'h0000_0000;
      tick_o <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 32'h0000_0001;
      tick_o <= 1'b0;
    end
  end

endmodule // jpm_tick

`default_nettype wire

// ### hdl/jpm_map_port.v
// CAN parameter-map port: broadcasts the controller's values as
// proprietary frames and accepts setpoint and save writes from a node.
// Assumes a CAN frame engine on the same clock that takes tx frames by
// valid/ready and presents received extended frames for one cycle.
//
// Operation
// - Every transmitted map frame starts its payload with A3 then AD.
// - A write of one to bit 16 of group FFBB saves values for good.
// - Another save needs that bit written back to zero first.
// - Every field is a raw integer, scale one, no offset.
// - While enabled the map frames go out once every second.
// - Map traffic is sent and accepted only while the map is enabled.
// - The map uses proprietary groups FF90 to FF95 and FFBB.
// - FF91 carries the writable minimum speed in bits 16 to 31.
// - FF92 carries the writable maximum speed in bits 16 to 31.
// - FF93 reports system voltage in tenths of a volt, bits 16-31.
// - FF93 reports oil pressure in kPa in bits 32 to 47.
// - FF95 reports the controller state code in bits 16 to 23.
//
// Added by the designer: register access over Wishbone and the register offsets.
`include "jpm_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module jpm_map_port #(
  parameter [31:0] TICK_CYCLES = `JPM_PERIOD_MS * `JPM_CLK_KHZ
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [4:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Live controller values
  input wire [15:0] eng_speed_i,
  input wire [15:0] tgt_speed_i,
  input wire [15:0] sys_volt_i,
  input wire [15:0] oil_press_i,
  input wire [15:0] eng_temp_i,
  input wire [31:0] eng_hours_i,
  input wire [15:0] fuel_level_i,
  input wire [7:0] ctl_state_i,
  input wire [15:0] state_timer_i,
  // Setpoints and save request to the controller
  output wire [15:0] min_speed_o,
  output wire [15:0] max_speed_o,
  output wire map_en_o,
  output reg save_o,
  // Transmit frame
  output reg tx_valid_o,
  input wire tx_ready_i,
  output reg [28:0] tx_id_o,
  output reg [63:0] tx_data_o,
  // Receive frame
  input wire rx_valid_i,
  input wire [28:0] rx_id_i,
  input wire [63:0] rx_data_i
);

  // Sequencer states
  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_LOAD = 2'd1;
  localparam [1:0] ST_SEND = 2'd2;

  // Merges write data into a register under the byte enables
  function [31:0] merge;
    input [31:0] old;
    input [31:0] wdat;
    input [3:0] sel;
    integer k;
    begin
      merge = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (sel[k]) begin
          merge[k*8 +: 8] = wdat[k*8 +: 8];
        end
      end
    end
  endfunction

  // Matches a qualified access against one register offset
  function hit;
    input req;
    input [4:0] adr;
    input [4:0] want;
    begin
      hit = req && (adr == want);
    end
  endfunction

  // Register file
  reg [31:0] ctrl_reg;
  reg [15:0] min_spd_reg;
  reg [15:0] max_spd_reg;
  reg save_armed_reg;
  reg [7:0] rx_cnt_reg;
  reg [7:0] save_cnt_reg;
  reg [7:0] burst_cnt_reg;

  // Sequencer
  reg [1:0] state_reg;
  reg [2:0] idx_reg;
  reg pend_reg;

  // Bus decode
  wire wb_req;
  wire wb_wr;
  wire [31:0] min_wr;
  wire [31:0] max_wr;
  wire map_en;
  wire [7:0] own_sa;

  // Receive decode
  wire rx_hit;
  wire [15:0] rx_pgn;
  wire rx_save_bit;
  wire rx_min;
  wire rx_max;
  wire rx_save;

  // Transmit frame contents
  reg [15:0] fr_pgn;
  reg [47:0] fr_body;
  wire tick;

  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_wr = wb_req & wb_we_i;
  assign min_wr = merge({16'h0000, min_spd_reg}, wb_dat_i, wb_sel_i);
  assign max_wr = merge({16'h0000, max_spd_reg}, wb_dat_i, wb_sel_i);
  assign map_en = ctrl_reg[`JPM_CTRL_EN];
  assign own_sa = ctrl_reg[`JPM_CTRL_SA_HI:`JPM_CTRL_SA_LO];
  assign map_en_o = map_en;
  assign min_speed_o = min_spd_reg;
  assign max_speed_o = max_spd_reg;

  // Period timer, runs only while the map is enabled
  jpm_tick #(
    .CYCLES(TICK_CYCLES)
  ) u_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .en_i(map_en),
    .tick_o(tick)
  );

  // Accepts a received frame only when all identifier checks pass
  assign rx_pgn = rx_id_i[23:8];
  assign rx_save_bit = rx_data_i[`JPM_SAVE_BIT];
  assign rx_hit = rx_valid_i & map_en
    & (rx_id_i[28:24] == `JPM_PRIO)
    & (rx_id_i[7:0] == `JPM_HOST_SA)
    & (rx_data_i[7:0] == `JPM_RX_TAG0)
    & (rx_data_i[15:8] == `JPM_RX_TAG1);

  // Accepted frames sorted by the group they address
  assign rx_min = rx_hit & (rx_pgn == `JPM_PGN_MINSPD);
  assign rx_max = rx_hit & (rx_pgn == `JPM_PGN_MAXSPD);
  assign rx_save = rx_hit & (rx_pgn == `JPM_PGN_SAVE);

  // Bus acknowledge one cycle after the request, dropped the next cycle
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
    end
  end

  // Read data, captured with the acknowledge; unmapped reads return zero
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_req && !wb_we_i) begin
      case (wb_adr_i)
        `JPM_REG_CTRL: wb_dat_o <= ctrl_reg;
        `JPM_REG_MINSPD: wb_dat_o <= {16'h0000, min_spd_reg};
        `JPM_REG_MAXSPD: wb_dat_o <= {16'h0000, max_spd_reg};
        `JPM_REG_STATUS: begin
          wb_dat_o <= {burst_cnt_reg, save_cnt_reg, rx_cnt_reg,
                       5'h00, pend_reg, (state_reg != ST_IDLE),
                       save_armed_reg};
        end
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // Control register; only enable and own address bits are kept
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= `JPM_CTRL_RST;
    end else if (hit(wb_wr, wb_adr_i, `JPM_REG_CTRL)) begin
      ctrl_reg <= merge(ctrl_reg, wb_dat_i, wb_sel_i) & 32'h0000_FF01;
    end
  end

  // Speed setpoints; a bus write in the same cycle beats a CAN write
  always @(posedge clk_i) begin
    if (rst_i) begin
      min_spd_reg <= `JPM_MINSPD_RST;
      max_spd_reg <= `JPM_MAXSPD_RST;
    end else begin
      if (hit(wb_wr, wb_adr_i, `JPM_REG_MINSPD)) begin
        min_spd_reg <= min_wr[15:0];
      end else if (rx_min) begin
        min_spd_reg <= rx_data_i[31:16];
      end
      if (hit(wb_wr, wb_adr_i, `JPM_REG_MAXSPD)) begin
        max_spd_reg <= max_wr[15:0];
      end else if (rx_max) begin
        max_spd_reg <= rx_data_i[31:16];
      end
    end
  end

  // Save handshake: one save per one, re-armed only by a zero
  always @(posedge clk_i) begin
    if (rst_i) begin
      save_armed_reg <= 1'b1;
      save_o <= 1'b0;
      save_cnt_reg <= 8'h00;
    end else begin
      save_o <= 1'b0;
      if (rx_save) begin
        if (!rx_save_bit) begin
          save_armed_reg <= 1'b1;
        end else if (save_armed_reg) begin
          save_armed_reg <= 1'b0;
          save_o <= 1'b1;
          save_cnt_reg <= save_cnt_reg + 8'h01;
        end
      end
    end
  end

  // Counts accepted frames; read-only groups are counted but change nothing
  always @(posedge clk_i) begin
    if (rst_i) begin
      rx_cnt_reg <= 8'h00;
    end else if (rx_hit) begin
      rx_cnt_reg <= rx_cnt_reg + 8'h01;
    end
  end

  // Payload body above the tag bytes for the frame at idx_reg
  always @* begin
    fr_pgn = `JPM_PGN_SPEED;
    fr_body = {48{1'b1}};
    case (idx_reg)
      3'd0: begin
        fr_pgn = `JPM_PGN_SPEED;
        fr_body = {{2{`JPM_FILL}}, tgt_speed_i, eng_speed_i};
      end
      3'd1: begin
        fr_pgn = `JPM_PGN_MINSPD;
        fr_body = {{4{`JPM_FILL}}, min_spd_reg};
      end
      3'd2: begin
        fr_pgn = `JPM_PGN_MAXSPD;
        fr_body = {{4{`JPM_FILL}}, max_spd_reg};
      end
      3'd3: begin
        fr_pgn = `JPM_PGN_ANALOG;
        fr_body = {eng_temp_i, oil_press_i, sys_volt_i};
      end
      3'd4: begin
        fr_pgn = `JPM_PGN_HOURS;
        fr_body = {fuel_level_i, eng_hours_i};
      end
      3'd5: begin
        fr_pgn = `JPM_PGN_STATE;
        fr_body = {{3{`JPM_FILL}}, state_timer_i, ctl_state_i};
      end
      3'd6: begin
        fr_pgn = `JPM_PGN_SAVE;
        fr_body = {{5{`JPM_FILL}}, 7'h7F, ~save_armed_reg};
      end
      default: begin
        fr_pgn = `JPM_PGN_SPEED;
        fr_body = {48{1'b1}};
      end
    endcase
  end

  // Broadcast sequencer: one burst of all map frames per period tick
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
      idx_reg <= 3'd0;
      pend_reg <= 1'b0;
      tx_valid_o <= 1'b0;
      tx_id_o <= 29'h0000_0000;
      tx_data_o <= 64'h0000_0000_0000_0000;
      burst_cnt_reg <= 8'h00;
    end else begin
      if (tick) begin
        pend_reg <= 1'b1;
      end
      case (state_reg)
        ST_IDLE: begin
          idx_reg <= 3'd0;
          if ((pend_reg || tick) && map_en) begin
            pend_reg <= 1'b0;
            state_reg <= ST_LOAD;
            burst_cnt_reg <= burst_cnt_reg + 8'h01;
          end else if (!map_en) begin
            pend_reg <= 1'b0;
          end
        end
        ST_LOAD: begin
          if (!map_en) begin
            state_reg <= ST_IDLE;
          end else begin
            tx_valid_o <= 1'b1;
            tx_id_o <= {`JPM_PRIO, fr_pgn, own_sa};
            tx_data_o <= {fr_body, `JPM_TX_TAG1, `JPM_TX_TAG0};
            state_reg <= ST_SEND;
          end
        end
        ST_SEND: begin
          // Frame stays stable until the frame engine takes it
          if (tx_ready_i) begin
            tx_valid_o <= 1'b0;
            if (idx_reg == `JPM_NFRAMES - 3'd1 || !map_en) begin
              state_reg <= ST_IDLE;
            end else begin
              idx_reg <= idx_reg + 3'd1;
              state_reg <= ST_LOAD;
            end
          end
        end
        default: begin
          state_reg <= ST_IDLE;
          tx_valid_o <= 1'b0;
        end
      endcase
    end
  end

endmodule // jpm_map_port

`default_nettype wire

// ### dv/jpm_checker.sv
// Checker for the map port: frame shape, write effects and saves.
// Bound to jpm_map_port; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module jpm_checker (
  // Clock, reset and bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_stb_i,
  // Map values
  input wire logic [15:0] min_speed_o,
  input wire logic [15:0] max_speed_o,
  input wire logic map_en_o,
  input wire logic save_o,
  // Frames
  input wire logic tx_valid_o,
  input wire logic tx_ready_i,
  input wire logic [28:0] tx_id_o,
  input wire logic [63:0] tx_data_o,
  input wire logic rx_valid_i,
  input wire logic [28:0] rx_id_i,
  input wire logic [63:0] rx_data_i
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic ok;
  logic armed;
  // Write frame that the port must take
  assign ok = rx_valid_i && map_en_o && rx_id_i[28:24] == 5'h18 &&
    rx_id_i[7:0] == 8'h70 && rx_data_i[15:0] == 16'hADA5;
  // Save arming as the node sees it
  always @(posedge clk_i) begin
    if (rst_i)
      armed <= 1'b1;
    else if (ok && rx_id_i[23:8] == 16'hFFBB)
      armed <= !rx_data_i[16];
  end
  chk_tx_tags: assert property (tx_valid_o |->
    tx_data_o[15:0] == 16'hADA3) else $error("tx tag");
  chk_tx_group: assert property (tx_valid_o |->
    tx_id_o[28:24] == 5'h18 && (tx_id_o[23:12] == 12'hFF9 ||
    tx_id_o[23:8] == 16'hFFBB)) else $error("tx group");
  chk_tx_hold: assert property (tx_valid_o && !tx_ready_i |=>
    tx_valid_o && $stable(tx_id_o) && $stable(tx_data_o))
    else $error("tx hold");
  chk_tx_enable: assert property ($rose(tx_valid_o) |->
    $past(map_en_o)) else $error("tx disabled");
  chk_save_cause: assert property (save_o |-> $past(ok &&
    rx_id_i[23:8] == 16'hFFBB && rx_data_i[16])) else $error("save");
  chk_save_rearm: assert property (save_o |->
    $past(armed) ##1 !save_o) else $error("save rearm");
  chk_min_write: assert property (ok && !wb_stb_i &&
    rx_id_i[23:8] == 16'hFF91 |=> min_speed_o == $past(rx_data_i[31:16]))
    else $error("min");
  chk_max_write: assert property (ok && !wb_stb_i &&
    rx_id_i[23:8] == 16'hFF92 |=> max_speed_o == $past(rx_data_i[31:16]))
    else $error("max");
  chk_drop_frame: assert property (rx_valid_i && !ok &&
    !wb_stb_i |=> $stable(min_speed_o) && $stable(max_speed_o) && !save_o)
    else $error("drop");
endmodule // jpm_checker
`default_nettype wire

// ### dv/jpm_node_model.sv
// Frame engine and remote node facing the map port.
// Assumes one clock; send is called from the bench.
`timescale 1ns/1ps
`default_nettype none
module jpm_node_model (
  // Clock and pace
  input wire logic clk_i,
  input wire logic slow_i,
  // Frames from the port
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  input wire logic [28:0] tx_id_i,
  input wire logic [63:0] tx_data_i,
  // Frames to the port
  output logic rx_valid_o,
  output logic [28:0] rx_id_o,
  output logic [63:0] rx_data_o
);
  logic [28:0] got_id [$];
  logic [63:0] got_data [$];
  int got_t [$];
  int cyc = 0;
  logic [1:0] wait_q = 2'h0;
  initial begin
    tx_ready_o = 1'b0;
    rx_valid_o = 1'b0;
    rx_id_o = '0;
    rx_data_o = '0;
  end
  // Takes frames at once or after a stall
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    wait_q <= tx_valid_i ? wait_q + 2'h1 : 2'h0;
    tx_ready_o <= tx_valid_i && !tx_ready_o && (!slow_i || wait_q == 2'h3);
    if (tx_valid_i && tx_ready_o) begin
      got_id.push_back(tx_id_i);
      got_data.push_back(tx_data_i);
      got_t.push_back(cyc);
    end
  end
  // One write frame; lines scramble when idle
  task automatic send(input logic [15:0] pgn, input logic [15:0] tag,
    input logic [47:0] body);
    @(posedge clk_i);
    rx_valid_o <= 1'b1;
    rx_id_o <= {5'h18, pgn, 8'h70};
    rx_data_o <= {body, tag};
    @(posedge clk_i);
    rx_valid_o <= 1'b0;
    rx_id_o <= ~rx_id_o;
    rx_data_o <= ~{body, tag};
  endtask
endmodule // jpm_node_model
`default_nettype wire

// ### dv/tb_jpm_map_port.sv
// Bench for the map port: registers, node writes, saves, broadcasts.
// Assumes jpm_node_model and the bound jpm_checker.
`timescale 1ns/1ps
`default_nettype none
module tb_jpm_map_port;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic slow = 1'b1;
  logic [4:0] adr = 5'h00;
  logic [31:0] wdat = 32'h0, rdat, rq;
  logic ack, en, save, txv, txr, rxv;
  logic [15:0] spd = 16'h0A1B, tgt = 16'h0C2D, volt = 16'h007D;
  logic [15:0] oil = 16'h0190, temp = 16'h0050, fuel = 16'h0042;
  logic [15:0] timer = 16'h0033, mn, mx;
  logic [31:0] hours = 32'h0001_2345;
  logic [7:0] state = 8'h00, nsave = 8'h00;
  logic [28:0] txid, rxid;
  logic [63:0] txd, rxd;
  int mismatches = 0;
  int n_checks = 0;
  always #5 clk_i = ~clk_i;
  jpm_map_port #(.TICK_CYCLES(32'd50)) jpm_map_port_i (.clk_i(clk_i),
    .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .eng_speed_i(spd), .tgt_speed_i(tgt),
    .sys_volt_i(volt), .oil_press_i(oil), .eng_temp_i(temp),
    .eng_hours_i(hours), .fuel_level_i(fuel), .ctl_state_i(state),
    .state_timer_i(timer), .min_speed_o(mn), .max_speed_o(mx),
    .map_en_o(en), .save_o(save), .tx_valid_o(txv), .tx_ready_i(txr),
    .tx_id_o(txid), .tx_data_o(txd), .rx_valid_i(rxv), .rx_id_i(rxid),
    .rx_data_i(rxd));
  jpm_node_model jpm_node_model_i (.clk_i(clk_i), .slow_i(slow),
    .tx_valid_i(txv), .tx_ready_o(txr), .tx_id_i(txid), .tx_data_i(txd),
    .rx_valid_o(rxv), .rx_id_o(rxid), .rx_data_o(rxd));
  // Counts save pulses
  always @(posedge clk_i) if (save === 1'b1) nsave <= nsave + 8'h01;
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One classic bus cycle, ended by the answer
  task automatic bus(input logic w, input logic [4:0] a,
    input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    rq = rdat;
    cyc <= 1'b0;
  endtask
  // Expected group number and payload of burst frame i
  function automatic logic [79:0] frame(input int i);
    case (i)
      0: return {16'hFF90, 16'hFFFF, tgt, spd, 16'hADA3};
      1: return {16'hFF91, 32'hFFFFFFFF, 16'h1234, 16'hADA3};
      2: return {16'hFF92, 32'hFFFFFFFF, 16'h5678, 16'hADA3};
      3: return {16'hFF93, temp, oil, volt, 16'hADA3};
      4: return {16'hFF94, fuel, hours, 16'hADA3};
      5: return {16'hFF95, 24'hFFFFFF, timer, 8'h00, 16'hADA3};
      default: return {16'hFFBB, 48'hFFFFFFFFFFFF, 16'hADA3};
    endcase
  endfunction
  task automatic t_rx;
    slow <= 1'b0;
    jpm_node_model_i.send(16'hFF91, 16'hADA5, 48'hFFFFFFFF1111);
    @(negedge clk_i);
    check(mn, 16'h0000);
    bus(1'b1, 5'h00, 32'h2A01);
    check(en, 1'b1);
    jpm_node_model_i.send(16'hFF91, 16'hADA5, 48'hFFFFFFFF1234);
    jpm_node_model_i.send(16'hFF92, 16'hADA5, 48'hFFFFFFFF5678);
    jpm_node_model_i.send(16'hFF91, 16'hADA4, 48'hFFFFFFFF0BAD);
    jpm_node_model_i.send(16'hFF93, 16'hADA5, 48'hFFFFFFFF0BAD);
    check(mn, 16'h1234);
    check(mx, 16'h5678);
    bus(1'b0, 5'h04, 32'h0);
    check(rq, 32'h1234);
    $display("rx test done");
  endtask
  task automatic t_save;
    jpm_node_model_i.send(16'hFFBB, 16'hADA5, 48'h1);
    jpm_node_model_i.send(16'hFFBB, 16'hADA5, 48'h1);
    jpm_node_model_i.send(16'hFFBB, 16'hADA5, 48'h0);
    jpm_node_model_i.send(16'hFFBB, 16'hADA5, 48'h1);
    repeat (2) @(posedge clk_i);
    check(nsave, 8'h02);
    $display("save test done");
  endtask
  task automatic t_tx;
    int n;
    logic [79:0] f;
    bus(1'b1, 5'h00, 32'h0);
    slow <= 1'b1;
    repeat (20) @(posedge clk_i);
    jpm_node_model_i.got_id.delete();
    jpm_node_model_i.got_data.delete();
    jpm_node_model_i.got_t.delete();
    bus(1'b1, 5'h00, 32'h2A01);
    for (int k = 0; k < 8; k++) begin
      repeat (300) if (jpm_node_model_i.got_id.size() < 7 * k + 7)
        @(posedge clk_i);
      check(jpm_node_model_i.got_data[7 * k + 5][23:16], k);
      state <= 8'(k + 1);
    end
    for (int i = 0; i < 7; i++) begin
      f = frame(i);
      check(jpm_node_model_i.got_id[i], {5'h18, f[79:64], 8'h2A});
      check(jpm_node_model_i.got_data[i], f[63:0]);
    end
    check(jpm_node_model_i.got_data[3][31:16], 16'h007D);
    check(jpm_node_model_i.got_data[3][47:32], 16'h0190);
    check(jpm_node_model_i.got_t[7] - jpm_node_model_i.got_t[0], 50);
    bus(1'b1, 5'h00, 32'h0);
    repeat (20) @(posedge clk_i);
    n = jpm_node_model_i.got_id.size();
    repeat (120) @(posedge clk_i);
    check(jpm_node_model_i.got_id.size(), n);
    $display("tx test done");
  endtask
  task automatic finish_test;
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Main sequence after a three-cycle reset
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_rx;
    t_save;
    t_tx;
    finish_test;
  end
  // Cuts a hang short
  initial begin
    #60000;
    mismatches++;
    finish_test;
  end
endmodule // tb_jpm_map_port
bind jpm_map_port jpm_checker jpm_checker_i (.clk_i(clk_i), .rst_i(rst_i),
  .wb_stb_i(wb_stb_i), .min_speed_o(min_speed_o),
  .max_speed_o(max_speed_o), .map_en_o(map_en_o), .save_o(save_o),
  .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i), .tx_id_o(tx_id_o),
  .tx_data_o(tx_data_o), .rx_valid_i(rx_valid_i), .rx_id_i(rx_id_i),
  .rx_data_i(rx_data_i));
`default_nettype wire
